// *** design/wdg_pkg.sv ***
// constants shared by the watchdog control block
package wdg_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS = 40;
  // stand-in for the slow oscillator: one tick per period below
  localparam int unsigned OSC_TICK_US = 100;
  localparam int unsigned TICK_CYC = (CLK_HZ / 1_000_000) * OSC_TICK_US;
  localparam int unsigned FAST_MS = 10;
  localparam int unsigned SLOW_MS = 20;
  localparam int unsigned FAST_TICKS = (FAST_MS * 1000) / OSC_TICK_US;
  localparam int unsigned SLOW_TICKS = (SLOW_MS * 1000) / OSC_TICK_US;
  localparam int unsigned RST_HOLD_NS = 640;
  localparam int unsigned RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SENSE_US = 20;
  localparam int unsigned SENSE_CYC = (CLK_HZ / 1_000_000) * SENSE_US;

  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STAT_ADDR = 8'h04;
  localparam logic [7:0] MASK_ADDR = 8'h08;

  localparam int unsigned RATE_BIT = 0;
  localparam int unsigned FLAG_BIT = 1;
  localparam int unsigned CC_BIT = 2;
  localparam int unsigned IE_BIT = 3;
  localparam int unsigned RE_BIT = 4;
  localparam int unsigned RESTART_BIT = 5;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  localparam int unsigned EV_TIMEOUT = 0;
  localparam int unsigned EV_CHECK = 1;
  localparam int unsigned EV_W = 2;
  localparam logic [1:0] EV_RESET = 2'h0;
endpackage

// *** design/wdg_tmr_if.sv ***
// link between control logic and the oscillator timer
`timescale 1ns/100ps
interface wdg_tmr_if;
  logic run;
  logic hold;
  logic restart;
  logic rate_fast;
  logic expire;
  modport ctrl (output run, output hold, output restart, output rate_fast, input expire);
  modport tmr (input run, input hold, input restart, input rate_fast, output expire);
endinterface

// *** design/wdg_osc_timer.sv ***
// oscillator tick divider and timeout counter
`timescale 1ns/100ps
module wdg_osc_timer #(
  parameter int unsigned TICK_CYC = wdg_pkg::TICK_CYC,
  parameter int unsigned TICK_W = 12,
  parameter int unsigned CNT_W = 8
) (
  input wire logic clk_i,   // system clock
  input wire logic rst_n_i, // sync reset, active low
  wdg_tmr_if.tmr t          // control side
);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
  localparam logic [CNT_W-1:0] FAST_LAST = CNT_W'(wdg_pkg::FAST_TICKS - 1);
  localparam logic [CNT_W-1:0] SLOW_LAST = CNT_W'(wdg_pkg::SLOW_TICKS - 1);

  logic [TICK_W-1:0] div, next_div;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic expire, next_expire;
  logic tick;
  logic [CNT_W-1:0] last;

  always_comb begin
    tick = t.run && (div == TICK_LAST);
    last = t.rate_fast ? FAST_LAST : SLOW_LAST;
    next_div = div;
    next_cnt = cnt;
    next_expire = 1'b0;
    if (!t.run) begin
      next_div = '0;
      next_cnt = '0;
    end else begin
      next_div = tick ? '0 : div + 1'b1;
      if (t.restart) begin
        next_cnt = '0;
      end else if (tick && !t.hold) begin
        if (cnt >= last) begin
          next_cnt = '0;
          next_expire = 1'b1;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div <= '0;
      cnt <= '0;
      expire <= 1'b0;
    end else begin
      div <= next_div;
      cnt <= next_cnt;
      expire <= next_expire;
    end
  end

  // registered so the flag and reset logic see one clean pulse
  assign t.expire = expire;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_EXPIRE_AT_END: assert property (expire |-> $past(cnt) == $past(last))
    else $error("timeout fired at wrong count");
  AST_HOLD_FREEZES: assert property (t.run && t.hold && !t.restart |=> $stable(cnt))
    else $error("counter moved while held");
  AST_RESTART_ZERO: assert property (t.run && t.restart |=> cnt == '0 && !expire)
    else $error("restart did not clear counter");
endmodule

// *** design/wdg_cyclic_check.sv ***
// cyclic sensing of hall and analog inputs
`timescale 1ns/100ps
module wdg_cyclic_check #(
  parameter int unsigned SENSE_CYC = wdg_pkg::SENSE_CYC
) (
  input wire logic clk_i,        // system clock
  input wire logic rst_n_i,      // sync reset, active low
  input wire logic start_i,      // pulse, begin one check
  input wire logic [1:0] hall_i, // two-pin hall sensor levels
  input wire logic analog_i,     // analog input comparator
  output logic sense_en_o,       // sensor supply on
  output logic hit_o             // pulse, input found active
);
  typedef enum logic [0:0] {IDLE, SENSE} chk_state_t;
  localparam logic [15:0] SENSE_LAST = 16'(SENSE_CYC - 1);

  chk_state_t state, next_state;
  logic [15:0] cnt, next_cnt;
  logic hit, next_hit;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_hit = 1'b0;
    unique case (state)
      IDLE: begin
        next_cnt = '0;
        if (start_i) begin
          next_state = SENSE;
        end
      end
      SENSE: begin
        // inputs only valid after the supply has settled
        if (cnt == SENSE_LAST) begin
          next_hit = (|hall_i) || analog_i;
          next_state = IDLE;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= IDLE;
      cnt <= '0;
      hit <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      hit <= next_hit;
    end
  end

  assign sense_en_o = (state == SENSE);
  assign hit_o = hit;
endmodule

// *** design/wdg_ctrl.sv ***
// autonomous watchdog control register, flags, reset and interrupt outputs
//
// How it works
// - A timeout with reset enabled pulls the system reset low, only in RUN mode.
// - The reset-enable bit can be set once and then stays set until reset.
// - With interrupt enable set, a set timeout flag requests a CPU interrupt in STOP mode.
// - The active-low interrupt pin is driven for a timeout only in STOP mode.
// - The cyclic-check bit turns on periodic sensing of hall and analog inputs.
// - The timeout flag is set each time the timeout period runs out.
// - Writing 1 clears the timeout flag and writing 0 leaves it alone.
// - Clearing the timeout flag also restarts the timeout period.
// - Rate select 1 gives the 10 ms period and 0 the 20 ms period.
// - Reset clears all control and flag bits to 0.
// - Writing 1 to the restart bit restarts the period; it always reads 0.
// - The oscillator runs only while reset, interrupt or check enable is set.
// - With only reset enable set, counting stops in STOP mode and resumes in RUN.
`timescale 1ns/100ps
module wdg_ctrl #(
  // clocks per oscillator tick; a bench may shorten it
  parameter int unsigned TICK_CYC = wdg_pkg::TICK_CYC
) (
  input wire logic clk_i,           // 25 MHz system clock
  input wire logic rst_n_i,         // sync reset, active low
  input wire logic psel_i,          // apb select
  input wire logic penable_i,       // apb enable
  input wire logic pwrite_i,        // apb direction
  input wire logic [7:0] paddr_i,   // apb byte address
  input wire logic [31:0] pwdata_i, // apb write data
  output logic [31:0] prdata_o,     // apb read data
  output logic pready_o,            // apb ready
  output logic pslverr_o,           // apb error, unmapped address
  input wire logic stop_mode_i,     // device in STOP mode
  input wire logic [1:0] hall_i,    // hall sensor inputs
  input wire logic analog_i,        // analog input comparator
  output logic sensor_supply_o,     // sensor supply during check
  output logic osc_run_o,           // watchdog oscillator running
  output logic sys_rst_n_o,         // system reset, active low
  output logic irq_a_n_o,           // cpu interrupt pin, active low
  output logic irq_o                // level interrupt from status
);
  wdg_tmr_if tif ();

  logic re, ie, cc, flag, rate;
  logic next_re, next_ie, next_cc, next_flag, next_rate;
  logic [wdg_pkg::EV_W-1:0] stat, next_stat, mask, next_mask;
  logic [4:0] rst_cnt, next_rst_cnt;
  logic sys_rst_n, next_sys_rst_n;
  logic irq_a_n, next_irq_a_n;
  logic wake_pend, next_wake_pend;
  logic [31:0] prdata, next_prdata;
  logic access, wr, ctrl_wr, stat_wr, mask_wr, mapped, hit;
  logic [7:0] ctrl_rd;
  logic [wdg_pkg::EV_W-1:0] ev;

  localparam logic [4:0] RST_HOLD = 5'(wdg_pkg::RST_HOLD_CYC);

  // apb decode; zero wait states
  always_comb begin
    access = psel_i && penable_i;
    wr = access && pwrite_i;
    mapped = (paddr_i == wdg_pkg::CTRL_ADDR) || (paddr_i == wdg_pkg::STAT_ADDR)
      || (paddr_i == wdg_pkg::MASK_ADDR);
    ctrl_wr = wr && (paddr_i == wdg_pkg::CTRL_ADDR);
    stat_wr = wr && (paddr_i == wdg_pkg::STAT_ADDR);
    mask_wr = wr && (paddr_i == wdg_pkg::MASK_ADDR);
  end

  assign pready_o = 1'b1;
  assign pslverr_o = access && !mapped;

  // timer control
  assign tif.run = re || ie || cc;
  // only the periodic functions keep counting in STOP
  assign tif.hold = stop_mode_i && !(ie || cc);
  assign tif.rate_fast = rate;
  assign tif.restart = ctrl_wr && (pwdata_i[wdg_pkg::RESTART_BIT]
    || pwdata_i[wdg_pkg::FLAG_BIT]);

  wdg_osc_timer #(
    .TICK_CYC (TICK_CYC),
    .TICK_W (12),
    .CNT_W (8)
  ) u_timer (
    .clk_i (clk_i),
    .rst_n_i (rst_n_i),
    .t (tif.tmr)
  );

  wdg_cyclic_check u_check (
    .clk_i (clk_i),
    .rst_n_i (rst_n_i),
    .start_i (tif.expire && cc),
    .hall_i (hall_i),
    .analog_i (analog_i),
    .sense_en_o (sensor_supply_o),
    .hit_o (hit)
  );

  // control register and flag
  always_comb begin
    next_re = re;
    next_ie = ie;
    next_cc = cc;
    next_rate = rate;
    next_flag = flag;
    if (ctrl_wr) begin
      // once enabled it cannot be turned off
      next_re = re || pwdata_i[wdg_pkg::RE_BIT];
      next_ie = pwdata_i[wdg_pkg::IE_BIT];
      next_cc = pwdata_i[wdg_pkg::CC_BIT];
      next_rate = pwdata_i[wdg_pkg::RATE_BIT];
      if (pwdata_i[wdg_pkg::FLAG_BIT]) begin
        next_flag = 1'b0;
      end
    end
    if (tif.expire) begin
      next_flag = 1'b1;
    end
  end

  // reset pulse and interrupt pin
  always_comb begin
    next_rst_cnt = rst_cnt;
    if (tif.expire && re && !stop_mode_i) begin
      next_rst_cnt = RST_HOLD;
    end else if (rst_cnt != 5'h00) begin
      next_rst_cnt = rst_cnt - 5'h01;
    end
    next_sys_rst_n = (next_rst_cnt == 5'h00);
    next_wake_pend = stop_mode_i && (wake_pend || hit);
    next_irq_a_n = !(stop_mode_i && ((ie && next_flag) || next_wake_pend));
  end

  // sticky status with mask
  always_comb begin
    ev = '0;
    ev[wdg_pkg::EV_TIMEOUT] = tif.expire;
    ev[wdg_pkg::EV_CHECK] = hit;
    next_stat = stat;
    if (stat_wr) begin
      next_stat = stat & ~pwdata_i[wdg_pkg::EV_W-1:0];
    end
    // an event in the clearing cycle is kept
    next_stat = next_stat | ev;
    next_mask = mask_wr ? pwdata_i[wdg_pkg::EV_W-1:0] : mask;
  end

  // read data captured in the setup phase
  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[wdg_pkg::RE_BIT] = re;
    ctrl_rd[wdg_pkg::IE_BIT] = ie;
    ctrl_rd[wdg_pkg::CC_BIT] = cc;
    ctrl_rd[wdg_pkg::FLAG_BIT] = flag;
    ctrl_rd[wdg_pkg::RATE_BIT] = rate; // restart bit stays 0
    next_prdata = prdata;
    if (psel_i && !penable_i && !pwrite_i) begin
      unique case (paddr_i)
        wdg_pkg::CTRL_ADDR: next_prdata = {24'h000000, ctrl_rd};
        wdg_pkg::STAT_ADDR: next_prdata = {30'h00000000, stat};
        wdg_pkg::MASK_ADDR: next_prdata = {30'h00000000, mask};
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      {re, ie, cc, flag, rate} <= 5'h00;
      stat <= wdg_pkg::EV_RESET;
      mask <= wdg_pkg::EV_RESET;
      rst_cnt <= 5'h00;
      sys_rst_n <= 1'b1;
      irq_a_n <= 1'b1;
      wake_pend <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      re <= next_re;
      ie <= next_ie;
      cc <= next_cc;
      flag <= next_flag;
      rate <= next_rate;
      stat <= next_stat;
      mask <= next_mask;
      rst_cnt <= next_rst_cnt;
      sys_rst_n <= next_sys_rst_n;
      irq_a_n <= next_irq_a_n;
      wake_pend <= next_wake_pend;
      prdata <= next_prdata;
    end
  end

  assign prdata_o = prdata;
  assign sys_rst_n_o = sys_rst_n;
  assign irq_a_n_o = irq_a_n;
  assign irq_o = |(stat & mask);
  assign osc_run_o = tif.run;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_RST_IN_RUN: assert property (tif.expire && re && !stop_mode_i |=> !sys_rst_n_o)
    else $error("timeout in run mode gave no reset");
  AST_NO_RST_UNARMED: assert property (!re && rst_cnt == 5'h00 |=> sys_rst_n_o)
    else $error("reset without reset enable");
  AST_RE_ONCE: assert property (re |=> re)
    else $error("reset enable was cleared");
  AST_IRQ_STOP: assert property (stop_mode_i && ie && flag && !ctrl_wr ##1 stop_mode_i
    |-> !irq_a_n_o)
    else $error("no interrupt for flag in stop");
  AST_IRQ_RUN_QUIET: assert property (!stop_mode_i |=> irq_a_n_o)
    else $error("interrupt pin driven in run mode");
  AST_FLAG_SET: assert property (tif.expire |=> flag)
    else $error("timeout did not set flag");
  AST_FLAG_W0: assert property (flag && ctrl_wr && !pwdata_i[wdg_pkg::FLAG_BIT] |=> flag)
    else $error("writing 0 cleared the flag");
  AST_FLAG_W1: assert property (flag && ctrl_wr && pwdata_i[wdg_pkg::FLAG_BIT] && !tif.expire
    |=> !flag)
    else $error("writing 1 did not clear the flag");
  AST_CLEAR_RESTARTS: assert property (ctrl_wr && pwdata_i[wdg_pkg::FLAG_BIT] |-> tif.restart)
    else $error("flag clear did not restart timer");
  AST_RESET_CLEARS: assert property (disable iff (1'b0) !rst_n_i |=> ctrl_rd == wdg_pkg::CTRL_RESET)
    else $error("control bits not cleared by reset");
  AST_OSC_OFF: assert property (!re && !ie && !cc |-> !osc_run_o)
    else $error("oscillator runs with all enables clear");
  AST_CHECK_ONLY_CC: assert property (!cc && !sensor_supply_o |=> !sensor_supply_o)
    else $error("cyclic check started while disabled");

  COV_RUN_RESET: cover property (tif.expire && re && !stop_mode_i);
  COV_STOP_IRQ: cover property (stop_mode_i && !irq_a_n_o);
  COV_CHECK_HIT: cover property (hit);
  COV_FLAG_CLEAR: cover property (flag && ctrl_wr && pwdata_i[wdg_pkg::FLAG_BIT]);
endmodule

// *** sim/mcu_core_model.sv ***
// core-side model: stop mode request and watchdog reset pulse monitor
`timescale 1ns/100ps
module mcu_core_model (
  input wire logic clk_i,       // system clock
  input wire logic rst_n_i,     // sync reset, active low
  input wire logic sys_rst_n_i, // reset from watchdog, active low
  input wire logic stop_req_i,  // software asks for STOP
  output logic stop_mode_o,     // device in STOP mode
  output logic [7:0] rst_cnt_o, // reset pulses seen
  output logic [15:0] rst_len_o // cycles low of last pulse
);
  logic last;
  // stop entry and exit only on a clock edge, as the core would
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      stop_mode_o <= 1'b0;
      rst_cnt_o <= 8'h00;
      rst_len_o <= 16'h0000;
      last <= 1'b1;
    end else begin
      stop_mode_o <= stop_req_i;
      last <= sys_rst_n_i;
      if (!sys_rst_n_i) begin
        rst_len_o <= last ? 16'h0001 : rst_len_o + 16'h0001;
      end
      if (last && !sys_rst_n_i) begin
        rst_cnt_o <= rst_cnt_o + 8'h01;
      end
    end
  end
endmodule

// *** sim/test_autonomous_watchdog_ctrl.sv ***
// register-level bench for the watchdog control block
`timescale 1ns/100ps
module test_autonomous_watchdog_ctrl;
  localparam int CYC_MAX = 20_000;
  // short oscillator tick keeps both periods within the run budget
  localparam int TK = 25;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] hall = 2'h1;
  logic analog = 1'b0;
  logic stop_req = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, stop_mode, supply, osc_run, sys_rst_n, irq_a_n, irq, er;
  logic [7:0] rst_cnt;
  logic [15:0] rst_len;
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  int n;
  always #20 clk_i = ~clk_i;
  wdg_ctrl #(.TICK_CYC(TK)) wdg_ctrl_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
    .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .stop_mode_i(stop_mode), .hall_i(hall),
    .analog_i(analog), .sensor_supply_o(supply), .osc_run_o(osc_run),
    .sys_rst_n_o(sys_rst_n), .irq_a_n_o(irq_a_n), .irq_o(irq));
  mcu_core_model mcu_core_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .sys_rst_n_i(sys_rst_n),
    .stop_req_i(stop_req), .stop_mode_o(stop_mode), .rst_cnt_o(rst_cnt), .rst_len_o(rst_len));
  task test_done;
    if (errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == CYC_MAX) begin
      errors++;
      test_done();
    end
  end
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task tick(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  // request held until pready is sampled high, data taken at that edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic e);
    int k;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      errors++;
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic e;
    apb(1'b1, a, d, e);
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] x, input string nm);
    logic e;
    apb(1'b0, a, 32'h0, e);
    chk(nm, x, rd);
  endtask
  task do_reset;
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    tick(10);
    rst_n_i <= 1'b1;
  endtask
  initial begin
    do_reset();
    rchk(wdg_pkg::CTRL_ADDR, 32'h0, "ctrl");
    rchk(wdg_pkg::STAT_ADDR, 32'h0, "stat");
    chk("outs", 32'h6, 32'({osc_run, sys_rst_n, irq_a_n, irq}));
    apb(1'b0, 8'h0c, 32'h0, er);
    chk("slverr", 32'h1, 32'(er));
    chk("unmapped", 32'h0, rd);
    wr(8'h10, 32'hff);
    wr(wdg_pkg::MASK_ADDR, 32'h1);
    wr(wdg_pkg::CTRL_ADDR, 32'h0d);
    wr(wdg_pkg::CTRL_ADDR, 32'h2d);
    rchk(wdg_pkg::CTRL_ADDR, 32'h0d, "ctrl");
    chk("osc_run", 32'h1, 32'(osc_run));
    // fast rate: nothing before the last tick of the period
    tick(wdg_pkg::FAST_TICKS * TK - TK - 20);
    chk("irq early", 32'h0, 32'(irq));
    n = 0;
    while (irq !== 1'b1 && n < TK + 100) begin
      @(posedge clk_i);
      n++;
    end
    chk("irq", 32'h1, 32'(irq));
    chk("supply", 32'h1, 32'(supply));
    chk("irq_a_n run", 32'h1, 32'(irq_a_n));
    tick(wdg_pkg::SENSE_CYC + 10);
    rchk(wdg_pkg::STAT_ADDR, 32'h3, "stat");
    rchk(wdg_pkg::CTRL_ADDR, 32'h0f, "ctrl");
    wr(wdg_pkg::MASK_ADDR, 32'h0);
    tick(2);
    chk("irq masked", 32'h0, 32'(irq));
    wr(wdg_pkg::MASK_ADDR, 32'h1);
    stop_req <= 1'b1;
    tick(4);
    chk("irq_a_n stop", 32'h0, 32'(irq_a_n));
    stop_req <= 1'b0;
    tick(4);
    chk("irq_a_n run", 32'h1, 32'(irq_a_n));
    wr(wdg_pkg::STAT_ADDR, 32'h3);
    tick(2);
    chk("irq cleared", 32'h0, 32'(irq));
    stop_req <= 1'b1;
    tick(4);
    chk("irq_a_n flag", 32'h0, 32'(irq_a_n));
    wr(wdg_pkg::CTRL_ADDR, 32'h05);
    tick(3);
    chk("irq_a_n off", 32'h1, 32'(irq_a_n));
    rchk(wdg_pkg::CTRL_ADDR, 32'h07, "ctrl");
    wr(wdg_pkg::CTRL_ADDR, 32'h07);
    rchk(wdg_pkg::CTRL_ADDR, 32'h05, "ctrl");
    stop_req <= 1'b0;
    wr(wdg_pkg::CTRL_ADDR, 32'h0);
    tick(2);
    chk("osc_run", 32'h0, 32'(osc_run));
    do_reset();
    rchk(wdg_pkg::CTRL_ADDR, 32'h0, "ctrl");
    wr(wdg_pkg::CTRL_ADDR, 32'h0);
    wr(wdg_pkg::CTRL_ADDR, 32'h10);
    rchk(wdg_pkg::CTRL_ADDR, 32'h10, "ctrl");
    wr(wdg_pkg::CTRL_ADDR, 32'h0);
    rchk(wdg_pkg::CTRL_ADDR, 32'h10, "ctrl");
    // slow rate outlives a fast period; after a restart the reset fires one slow period later
    tick(wdg_pkg::FAST_TICKS * TK + 500);
    chk("rst count", 32'h0, 32'(rst_cnt));
    wr(wdg_pkg::CTRL_ADDR, 32'h30);
    rchk(wdg_pkg::CTRL_ADDR, 32'h10, "ctrl");
    tick(wdg_pkg::SLOW_TICKS * TK - TK - 20);
    chk("rst count", 32'h0, 32'(rst_cnt));
    n = 0;
    while (sys_rst_n !== 1'b0 && n < TK + 100) begin
      @(posedge clk_i);
      n++;
    end
    chk("sys_rst_n", 32'h0, 32'(sys_rst_n));
    tick(40);
    chk("rst len", wdg_pkg::RST_HOLD_CYC, 32'(rst_len));
    do_reset();
    rchk(wdg_pkg::CTRL_ADDR, 32'h0, "ctrl");
    test_done();
  end
endmodule
